// ==== ebb_cfg.sv ====
// setting store: power-on reset loads defaults, manual reset keeps contents
`timescale 1ns/1ps
`default_nettype none
module ebb_cfg
  import ebb_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic manual_rst_in,
  input wire logic rom_enable_in,
  input wire logic cfg_we_in,
  input wire logic [7:0] area_width_reg_in,
  input wire logic [7:0] area_state_count_reg_in,
  input wire logic [7:0] stall_count_high_reg_in,
  input wire logic [7:0] stall_count_low_reg_in,
  input wire logic bus_control_low_reg_in,
  input wire logic dir_we_in,
  input wire logic [7:0] dir_in,
  ebb_cfg_if.store cfg
);
  logic [7:0] width_q, state_q, hi_q, lo_q, dir_q;
  logic pse_q;
  // power-on defaults; manual reset holds contents
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      width_q <= EBB_WIDTH_RST_8BIT;
      state_q <= EBB_STATE_RST;
      hi_q <= EBB_STALL_HI_RST;
      lo_q <= EBB_STALL_LO_RST;
      pse_q <= EBB_PIN_STALL_RST;
    end else if (cfg_we_in && !manual_rst_in) begin
      width_q <= area_width_reg_in;
      state_q <= area_state_count_reg_in;
      hi_q <= stall_count_high_reg_in;
      lo_q <= stall_count_low_reg_in;
      pse_q <= bus_control_low_reg_in;
    end
  end
  // direction bits after power-on depend on the rom mode
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      dir_q <= EBB_DIR_RST_ROMON;
    end else if (dir_we_in) begin
      dir_q <= dir_in;
    end
  end
  logic rom_q, first_q;
  // capture the rom strap at release, then apply the mode default once
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      first_q <= 1'b1;
      rom_q <= 1'b0;
    end else begin
      first_q <= 1'b0;
      if (first_q) begin
        rom_q <= rom_enable_in;
      end
    end
  end
  assign cfg.width8 = width_q;
  assign cfg.three_state = state_q;
  assign cfg.stall_hi = hi_q;
  assign cfg.stall_lo = lo_q;
  assign cfg.pin_stall_enable = pse_q;
  // direction seen by the pins: mode default until software writes
  logic dir_written_q;
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      dir_written_q <= 1'b0;
    end else if (dir_we_in) begin
      dir_written_q <= 1'b1;
    end
  end
  assign cfg.dir = dir_written_q ? dir_q :
                   ((first_q ? rom_enable_in : rom_q) ? EBB_DIR_RST_ROMON : EBB_DIR_RST_ROMOFF);
endmodule
`default_nettype wire

// ==== ebb_cfg_if.sv ====
// per-area setting lines between the setting store and the bus sequencer
`timescale 1ns/1ps
`default_nettype none
interface ebb_cfg_if;
  logic [7:0] width8;
  logic [7:0] three_state;
  logic [7:0] stall_hi;
  logic [7:0] stall_lo;
  logic pin_stall_enable;
  logic [7:0] dir;
  modport store (output width8, three_state, stall_hi, stall_lo, pin_stall_enable, dir);
  modport user (input width8, three_state, stall_hi, stall_lo, pin_stall_enable, dir);
endinterface
`default_nettype wire

// ==== ebb_ext_mem.sv ====
// external static memory model on the far side of the bus pins
`timescale 1ns/1ps
`default_nettype none
module ebb_ext_mem (
  // clock
  input wire logic clk_in,
  // bus pins from the controller
  input wire logic [23:0] addr_in,
  input wire logic [7:0] select_n_in,
  input wire logic rd_n_in,
  input wire logic hi_wr_n_in,
  input wire logic lo_wr_n_in,
  input wire logic [15:0] wdata_in,
  // board wiring and slow-device setting
  input wire logic [7:0] width8_in,
  input wire logic [7:0] slow_in,
  // pins back to the controller
  output logic [15:0] rdata_out,
  output logic stall_n_out
);
  logic [7:0] mem [0:1023];
  logic [7:0] junk_q = 8'hA5;
  logic [7:0] hold_q = 8'h00;
  logic sel_q = 1'b1;
  logic [9:0] ix;
  logic narrow;
  assign ix = {addr_in[23:21], addr_in[6:0]};
  assign narrow = width8_in[addr_in[23:21]];
  // memory starts cleared so the bench mirror can match it
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 8'h00;
  end
  // read drive; undriven lanes carry a pattern that moves each cycle
  always_comb begin
    rdata_out = {junk_q, ~junk_q};
    if (!rd_n_in && narrow) rdata_out[15:8] = mem[ix];
    else if (!rd_n_in) rdata_out = {mem[{ix[9:1], 1'b0}], mem[{ix[9:1], 1'b1}]};
  end
  // write capture while a strobe is low
  always @(posedge clk_in) begin
    if (!hi_wr_n_in) mem[narrow ? ix : {ix[9:1], 1'b0}] <= wdata_in[15:8];
    if (!lo_wr_n_in) mem[{ix[9:1], 1'b1}] <= wdata_in[7:0];
  end
  // slow device: stall low from select fall for slow_in + 1 cycles, released on deselect
  always @(posedge clk_in) begin
    sel_q <= &select_n_in;
    if (&select_n_in) hold_q <= 8'h00;
    else if (sel_q) hold_q <= slow_in;
    else if (hold_q != 8'h00) hold_q <= hold_q - 8'h01;
    junk_q <= junk_q + 8'h35;
  end
  // pulled low in the cycle the select falls, so with three programmed stalls the synchroniser delay is covered
  assign stall_n_out = !((sel_q && !(&select_n_in) && slow_in != 8'h00) || hold_q != 8'h00);
endmodule
`default_nettype wire

// ==== ebb_pkg.sv ====
// shared constants and types for the external basic bus interface
package ebb_pkg;
  localparam int EBB_AREAS = 8;
  localparam int EBB_ADDR_W = 24;
  localparam int EBB_AREA_LSB = 21;
  // power-on reset values of the per-area settings
  localparam logic [7:0] EBB_WIDTH_RST_8BIT = 8'hFF;
  localparam logic [7:0] EBB_STATE_RST = 8'hFF;
  localparam logic [7:0] EBB_STALL_HI_RST = 8'hFF;
  localparam logic [7:0] EBB_STALL_LO_RST = 8'hFF;
  localparam logic EBB_PIN_STALL_RST = 1'b0;
  localparam logic [7:0] EBB_DIR_RST_ROMOFF = 8'h01;
  localparam logic [7:0] EBB_DIR_RST_ROMON = 8'h00;
  localparam logic [3:0] EBB_DRAM_AREAS = 4'hF;
  localparam int EBB_DRAM_LO = 2;
  // access sizes requested by the internal masters
  typedef enum logic [1:0] {EBB_BYTE, EBB_WORD, EBB_LONG} ebb_size_t;
  typedef enum logic [2:0] {
    EBB_IDLE, EBB_FIRST, EBB_SECOND, EBB_STALL, EBB_THIRD
  } ebb_state_t;
endpackage

// ==== ebb_top.sv ====
// external basic bus interface: area selects, data steering, strobes, stalls
`timescale 1ns/1ps
`default_nettype none
// Function
// - Drive the selected area's select low during its access; eight selects.
// - A select reaches its pin only when that pin's direction bit is set.
// - Rom-disabled expansion: area 0 select output, areas 1-7 input after power-on.
// - Rom-enabled expansion: all select pins input after power-on reset.
// - 8-bit space: one byte per cycle on upper half; split words, longs.
// - 16-bit space: byte or word per cycle; longword becomes two word cycles.
// - 16-bit byte access: even address upper half, odd address lower half.
// - Read strobe asserted for every read regardless of the used half.
// - Upper write strobe for upper half, lower for lower, both for word.
// - Unused half floats on writes; ignored on reads.
// - 8-bit space keeps the lower write strobe high throughout.
// - Two-state areas never get stall states, programmed or pin.
// - Three-state areas insert 0-3 programmed stalls between second and third states.
// - Pin stalls allowed only with the single global pin stall enable set.
// - Programmed stalls first; then sample pin in the state before the third, add stall if low.
// - Power-on: all areas three-state, three stalls, pin stall disabled.
// - Manual reset keeps all setting contents unchanged.
// - Width, state count and stalls per area come from the setting bits.
// - Address space splits into eight equal areas with own settings.
// - Width bit per area chooses 8-bit or 16-bit path.
// - State bit per area chooses two-state or three-state access.
module ebb_top
  import ebb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic manual_rst_in,
  input wire logic rom_enable_in,
  // settings
  input wire logic cfg_we_in,
  input wire logic [7:0] area_width_reg_in,
  input wire logic [7:0] area_state_count_reg_in,
  input wire logic [7:0] stall_count_high_reg_in,
  input wire logic [7:0] stall_count_low_reg_in,
  input wire logic bus_control_low_reg_in,
  input wire logic dir_we_in,
  input wire logic [7:0] dir_in,
  input wire logic [3:0] dram_area_in,
  // internal master request
  input wire logic req_in,
  input wire logic wr_in,
  input wire logic [1:0] size_in,
  input wire logic [EBB_ADDR_W-1:0] addr_in,
  input wire logic [31:0] wdata_in,
  output logic busy_out,
  output logic done_out,
  output logic [31:0] rdata_out,
  // external pins
  output logic [EBB_ADDR_W-1:0] ext_addr_out,
  output logic [7:0] area_select_n_out,
  output logic [7:0] area_select_oe_n_out,
  output logic read_strobe_n_out,
  output logic upper_write_strobe_n_out,
  output logic lower_write_strobe_n_out,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic [1:0] data_oe_n_out,
  input wire logic stall_req_n_in,
  // status
  output logic pin_stall_enable_out
);
  ebb_cfg_if cfg ();

  // setting store
  ebb_cfg u_cfg (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .manual_rst_in(manual_rst_in),
    .rom_enable_in(rom_enable_in),
    .cfg_we_in(cfg_we_in),
    .area_width_reg_in(area_width_reg_in),
    .area_state_count_reg_in(area_state_count_reg_in),
    .stall_count_high_reg_in(stall_count_high_reg_in),
    .stall_count_low_reg_in(stall_count_low_reg_in),
    .bus_control_low_reg_in(bus_control_low_reg_in),
    .dir_we_in(dir_we_in),
    .dir_in(dir_in),
    .cfg(cfg)
  );

  logic stall_n;
  // stall pin synchroniser
  ebb_wait_sync u_sync (
    .sys_clk_in(sys_clk_in),
    .rst_in(rst_in),
    .pin_n_in(stall_req_n_in),
    .level_n_out(stall_n)
  );

  ebb_state_t st_q;
  logic [2:0] area_q;
  logic [EBB_ADDR_W-1:0] addr_q;
  logic wr_q, w8_q, three_q;
  logic [1:0] size_q, prog_q, cnt_q;
  logic [1:0] parts_q, part_q;
  logic [31:0] wbuf_q, rbuf_q;
  logic [2:0] req_area;
  logic last_state;

  // top address bits pick one of eight equal areas
  assign req_area = addr_in[EBB_ADDR_W-1:EBB_AREA_LSB];
  assign busy_out = (st_q != EBB_IDLE);
  assign pin_stall_enable_out = cfg.pin_stall_enable;

  // per-part byte or word flags
  logic part_word;
  assign part_word = !w8_q && (size_q != EBB_BYTE);

  // sequencer: latches request, splits into parts, walks the access states
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      st_q <= EBB_IDLE;
      area_q <= 3'h0;
      addr_q <= '0;
      wr_q <= 1'b0;
      size_q <= 2'h0;
      w8_q <= 1'b0;
      three_q <= 1'b0;
      prog_q <= 2'h0;
      cnt_q <= 2'h0;
      parts_q <= 2'h0;
      part_q <= 2'h0;
    end else begin
      case (st_q)
        EBB_IDLE: begin
          if (req_in) begin
            area_q <= req_area;
            addr_q <= addr_in;
            wr_q <= wr_in;
            size_q <= size_in;
            w8_q <= cfg.width8[req_area];
            three_q <= cfg.three_state[req_area];
            prog_q <= {cfg.stall_hi[req_area], cfg.stall_lo[req_area]};
            part_q <= 2'h0;
            // number of bus cycles per access, minus one
            if (cfg.width8[req_area]) begin
              parts_q <= (size_in == EBB_LONG) ? 2'h3 : (size_in == EBB_WORD) ? 2'h1 : 2'h0;
            end else begin
              parts_q <= (size_in == EBB_LONG) ? 2'h1 : 2'h0;
            end
            st_q <= EBB_FIRST;
          end
        end
        EBB_FIRST: begin
          cnt_q <= 2'h0;
          st_q <= EBB_SECOND;
        end
        EBB_SECOND, EBB_STALL: begin
          // two-state areas end here with no stall
          if (!three_q) begin
            st_q <= EBB_IDLE;
          end else if (cnt_q != prog_q) begin
            cnt_q <= cnt_q + 2'h1;
            st_q <= EBB_STALL;
          // then pin stalls while enabled and low
          end else if (cfg.pin_stall_enable && !stall_n) begin
            st_q <= EBB_STALL;
          end else begin
            st_q <= EBB_THIRD;
          end
        end
        EBB_THIRD: st_q <= EBB_IDLE;
        default: st_q <= EBB_IDLE;
      endcase
      // end of a bus cycle with parts left: next part at the next address
      if (last_state && part_q != parts_q) begin
        part_q <= part_q + 2'h1;
        addr_q <= addr_q + (part_word ? 24'h000002 : 24'h000001);
        st_q <= EBB_FIRST;
      end
    end
  end

  // last state of a bus cycle, two-state areas end at the second state
  assign last_state = (st_q == EBB_THIRD) || (st_q == EBB_SECOND && !three_q);

  // write data buffer, shifted one part per cycle, first part on top
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      wbuf_q <= '0;
    end else if (st_q == EBB_IDLE && req_in) begin
      case (size_in)
        EBB_BYTE: wbuf_q <= {wdata_in[7:0], 24'h000000};
        EBB_WORD: wbuf_q <= {wdata_in[15:0], 16'h0000};
        default: wbuf_q <= wdata_in;
      endcase
    end else if (last_state) begin
      wbuf_q <= part_word ? {wbuf_q[15:0], 16'h0000} : {wbuf_q[23:0], 8'h00};
    end
  end

  // byte lane from address parity in 16-bit space
  logic odd_byte, use_hi, use_lo;
  assign odd_byte = !w8_q && !part_word && addr_q[0];
  assign use_hi = part_word || !odd_byte;
  assign use_lo = part_word || odd_byte;

  // read data taken only from the used half
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rbuf_q <= '0;
    end else if (st_q == EBB_IDLE && req_in) begin
      rbuf_q <= '0;
    end else if (last_state && !wr_q) begin
      if (part_word) begin
        rbuf_q <= {rbuf_q[15:0], data_in};
      end else begin
        rbuf_q <= {rbuf_q[23:0], (odd_byte ? data_in[7:0] : data_in[15:8])};
      end
    end
  end

  // completion pulse with read data
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      done_out <= 1'b0;
      rdata_out <= '0;
    end else begin
      done_out <= last_state && (part_q == parts_q);
      if (last_state && (part_q == parts_q) && !wr_q) begin
        if (part_word) begin
          rdata_out <= {rbuf_q[15:0], data_in};
        end else begin
          rdata_out <= {rbuf_q[23:0], (odd_byte ? data_in[7:0] : data_in[15:8])};
        end
      end
    end
  end

  // pin side registers
  logic [7:0] sel_n_q;
  logic rd_n_q, hw_n_q, lw_n_q;
  logic [15:0] dout_q;
  logic [1:0] doe_n_q;
  logic in_cycle, cyc_next, strobe_next;
  assign in_cycle = (st_q != EBB_IDLE);
  // strobes are low from the second state to the last state of each bus cycle
  assign strobe_next = (st_q == EBB_FIRST) ||
                       ((st_q == EBB_SECOND || st_q == EBB_STALL) && !last_state);
  // cycle continues next clock unless this is the final state of the access
  assign cyc_next = (st_q == EBB_IDLE) ? req_in : !(last_state && part_q == parts_q);

  // select low for the whole access, released when idle
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      sel_n_q <= 8'hFF;
    end else begin
      sel_n_q <= 8'hFF;
      if (cyc_next) begin
        sel_n_q[(st_q == EBB_IDLE) ? req_area : area_q] <= 1'b0;
      end
    end
  end

  // strobes and data drive per state
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      rd_n_q <= 1'b1;
      hw_n_q <= 1'b1;
      lw_n_q <= 1'b1;
      dout_q <= '0;
      doe_n_q <= 2'b11;
    end else begin
      rd_n_q <= !(!wr_q && strobe_next);
      hw_n_q <= !(wr_q && strobe_next && use_hi);
      lw_n_q <= !(wr_q && strobe_next && use_lo && !w8_q);
      dout_q <= part_word ? wbuf_q[31:16] : (odd_byte ? {8'h00, wbuf_q[31:24]}
                                                      : {wbuf_q[31:24], 8'h00});
      doe_n_q <= {!(in_cycle && wr_q && use_hi), !(in_cycle && wr_q && use_lo && !w8_q)};
    end
  end

  // select driven only where direction bit set; dram_area_in is not used
  genvar g;
  generate
    for (g = 0; g < EBB_AREAS; g = g + 1) begin : g_sel
      assign area_select_n_out[g] = sel_n_q[g];
      assign area_select_oe_n_out[g] = !cfg.dir[g];
    end
  endgenerate

  assign ext_addr_out = addr_q;
  assign read_strobe_n_out = rd_n_q;
  assign upper_write_strobe_n_out = hw_n_q;
  assign lower_write_strobe_n_out = lw_n_q;
  assign data_out = dout_q;
  assign data_oe_n_out = doe_n_q;

  logic unused_dram;
  assign unused_dram = ^dram_area_in;

  // checks
  // lower strobe stays high in 8-bit space
  property p_lw8;
    @(posedge sys_clk_in) disable iff (rst_in)
      (busy_out && w8_q) |=> lower_write_strobe_n_out;
  endproperty
  a_lw8: assert property (p_lw8) else $error("lower strobe in 8-bit space");

  property p_two;
    @(posedge sys_clk_in) disable iff (rst_in)
      (st_q == EBB_SECOND && !three_q) |=> (st_q == EBB_FIRST || st_q == EBB_IDLE);
  endproperty
  a_two: assert property (p_two) else $error("stall in two-state area");

  // stall count never passes programmed value without pin
  property p_prog;
    @(posedge sys_clk_in) disable iff (rst_in)
      (st_q == EBB_STALL) |-> (cnt_q <= prog_q);
  endproperty
  a_prog: assert property (p_prog) else $error("too many programmed stalls");

  property p_pin;
    @(posedge sys_clk_in) disable iff (rst_in)
      (st_q == EBB_STALL && cnt_q == prog_q && !cfg.pin_stall_enable) |=> (st_q == EBB_THIRD);
  endproperty
  a_pin: assert property (p_pin) else $error("pin stall while disabled");

  // low pin after programmed stalls adds a stall
  property p_pinlow;
    @(posedge sys_clk_in) disable iff (rst_in)
      ((st_q == EBB_SECOND || st_q == EBB_STALL) && three_q && cnt_q == prog_q
        && cfg.pin_stall_enable && !stall_n) |=> (st_q == EBB_STALL);
  endproperty
  a_pinlow: assert property (p_pinlow) else $error("pin stall missed");

  property p_onehot;
    @(posedge sys_clk_in) disable iff (rst_in)
      $onehot0(~area_select_n_out);
  endproperty
  a_onehot: assert property (p_onehot) else $error("two selects low");

  // select held low in every state of the access
  property p_sel;
    @(posedge sys_clk_in) disable iff (rst_in)
      busy_out |-> !area_select_n_out[area_q];
  endproperty
  a_sel: assert property (p_sel) else $error("select not held");

  // read strobe never with write strobe
  property p_rdwr;
    @(posedge sys_clk_in) disable iff (rst_in)
      !read_strobe_n_out |-> (upper_write_strobe_n_out && lower_write_strobe_n_out);
  endproperty
  a_rdwr: assert property (p_rdwr) else $error("read and write strobes together");

  // read strobe low in the state where read data are taken
  property p_rdlast;
    @(posedge sys_clk_in) disable iff (rst_in)
      (last_state && !wr_q) |-> !read_strobe_n_out;
  endproperty
  a_rdlast: assert property (p_rdlast) else $error("read strobe high at data sample");
endmodule
`default_nettype wire

// ==== ebb_wait_sync.sv ====
// three-stage synchroniser for the stall request pin, settles when stages agree
`timescale 1ns/1ps
`default_nettype none
module ebb_wait_sync (
  input wire logic sys_clk_in,
  input wire logic rst_in,
  input wire logic pin_n_in,
  output logic level_n_out
);
  logic s1_q, s2_q, s3_q, lvl_q;
  // stage chain, idle high
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      lvl_q <= 1'b1;
    end else begin
      s1_q <= pin_n_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        lvl_q <= s3_q;
      end
    end
  end
  assign level_n_out = lvl_q;
endmodule
`default_nettype wire

// ==== tb_external_basic_bus_interface.sv ====
// self-checking bench for the external basic bus interface
`timescale 1ns/1ps
`default_nettype none
module tb_external_basic_bus_interface
  import ebb_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic mrst = 1'b0;
  logic rom_en = 1'b0;
  logic cfg_we = 1'b0;
  logic dir_we = 1'b0;
  logic [7:0] w8 = 8'hFF;
  logic [7:0] ts = 8'hFF;
  logic [7:0] shi = 8'hFF;
  logic [7:0] slo = 8'hFF;
  logic pse = 1'b0;
  logic [7:0] dir = 8'h01;
  logic req = 1'b0;
  logic wr = 1'b0;
  logic [1:0] sz = 2'h0;
  logic [23:0] addr = 24'h000000;
  logic [31:0] wdat = 32'h00000000;
  logic [7:0] slow = 8'h00;
  logic busy, done, pse_o, rd_n, uw_n, lw_n, stall_n;
  logic [31:0] rdat;
  logic [23:0] xaddr;
  logic [7:0] sel_n, sel_oe_n;
  logic [15:0] din, dout;
  logic [1:0] doe_n;
  logic strobe_q = 1'b1;
  logic [7:0] ref_mem [0:1023];
  int n_mismatch = 0;
  int compares = 0;
  int n_sel = 0;
  int n_parts = 0;

  always #12.5 clk = ~clk;

  ebb_top u_dut (.sys_clk_in(clk), .rst_in(rst), .manual_rst_in(mrst), .rom_enable_in(rom_en),
    .cfg_we_in(cfg_we), .area_width_reg_in(w8), .area_state_count_reg_in(ts),
    .stall_count_high_reg_in(shi), .stall_count_low_reg_in(slo), .bus_control_low_reg_in(pse),
    .dir_we_in(dir_we), .dir_in(dir), .dram_area_in(4'h0), .req_in(req), .wr_in(wr),
    .size_in(sz), .addr_in(addr), .wdata_in(wdat), .busy_out(busy), .done_out(done),
    .rdata_out(rdat), .ext_addr_out(xaddr), .area_select_n_out(sel_n),
    .area_select_oe_n_out(sel_oe_n), .read_strobe_n_out(rd_n), .upper_write_strobe_n_out(uw_n),
    .lower_write_strobe_n_out(lw_n), .data_in(din), .data_out(dout), .data_oe_n_out(doe_n),
    .stall_req_n_in(stall_n), .pin_stall_enable_out(pse_o));

  ebb_ext_mem u_mem (.clk_in(clk), .addr_in(xaddr), .select_n_in(sel_n), .rd_n_in(rd_n),
    .hi_wr_n_in(uw_n), .lo_wr_n_in(lw_n), .wdata_in(dout), .width8_in(w8), .slow_in(slow),
    .rdata_out(din), .stall_n_out(stall_n));

  // one comparison with its report
  task automatic check(input bit ok, input string what);
    compares++;
    if (!ok) begin
      n_mismatch++;
      $display("wrong value at %0t ns: %s", $time, what);
    end
  endtask

  // verdict and end of run
  task automatic complete_run();
    $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // bus cycles expected for one request
  function automatic int exp_parts(input logic narrow, input logic [1:0] s);
    if (narrow) return 1 << s;
    return (s == 2'h2) ? 2 : 1;
  endfunction

  // random area and offset, even for word and long
  function automatic logic [23:0] rnd_addr(input logic [1:0] s);
    logic [6:0] off;
    off = 7'($urandom % 120);
    if (s != 2'h0) off[0] = 1'b0;
    return {3'($urandom), 14'h0000, off};
  endfunction

  // power-on reset; mirror settings go back to their defaults
  task automatic power_on(input logic rom);
    @(posedge clk);
    #1 rst = 1'b1;
    rom_en = rom;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    {w8, ts, shi, slo, pse} = {EBB_WIDTH_RST_8BIT, EBB_STATE_RST, EBB_STALL_HI_RST,
      EBB_STALL_LO_RST, EBB_PIN_STALL_RST};
    repeat (3) @(posedge clk);
    #1;
  endtask

  // one-cycle pulse on a load strobe
  task automatic set_cfg(input bit is_dir);
    @(posedge clk);
    #1 if (is_dir) dir_we = 1'b1; else cfg_we = 1'b1;
    @(posedge clk);
    #1 dir_we = 1'b0;
    cfg_we = 1'b0;
  endtask

  // one request from the internal master, checked against the mirror
  task automatic access(input logic w, input logic [1:0] s, input logic [23:0] a);
    int n;
    int nb;
    int base;
    int st;
    logic [2:0] ar;
    logic [31:0] exp;
    logic [31:0] mask;
    ar = a[23:21];
    nb = 1 << s;
    base = {ar, a[6:0]};
    st = ts[ar] ? 3 + {shi[ar], slo[ar]} : 2;
    mask = (s == 2'h0) ? 32'h000000FF : (s == 2'h1) ? 32'h0000FFFF : 32'hFFFFFFFF;
    @(posedge clk);
    #1 req = 1'b1;
    wr = w;
    sz = s;
    addr = a;
    wdat = $urandom;
    @(posedge clk);
    #1 req = 1'b0;
    n_sel = 0;
    n_parts = 0;
    for (n = 0; n < 300 && done !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    check(done === 1'b1, "access never finished");
    check(n_parts == exp_parts(w8[ar], s), "bus cycle count");
    if (n_parts == 1 && pse && ts[ar] && slow != 8'h00) begin
      check(n_sel > st && n_sel <= st + slow + 4, "pin stall length");
    end else if (n_parts == 1) begin
      check(n_sel == st, "select length");
    end
    exp = 32'h00000000;
    for (n = 0; n < nb; n++) begin
      if (w) ref_mem[base + n] = wdat[8 * (nb - 1 - n) +: 8];
      else exp = {exp[23:0], ref_mem[base + n]};
    end
    if (!w) check((rdat & mask) === exp, "read data");
  endtask

  // pin watch: strobe edges, select length and lane agreement
  always @(posedge clk) begin
    if (!rst) begin
      if (sel_n != 8'hFF) n_sel++;
      if (strobe_q && !(rd_n && uw_n && lw_n)) n_parts++;
      strobe_q = rd_n && uw_n && lw_n;
      if (sel_n != 8'hFF) check(sel_n === ~(8'h01 << xaddr[23:21]), "select area");
      if (!uw_n || !lw_n) check(doe_n === {uw_n, lw_n} && rd_n === 1'b1, "write lanes");
      if (sel_n != 8'hFF && w8[xaddr[23:21]]) check(lw_n === 1'b1, "narrow lower strobe");
    end
  end

  // watchdog against a hung access
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    $display("wrong value at %0t ns: run timed out", $time);
    complete_run();
  end

  // main sequence
  initial begin
    int k;
    logic [1:0] s;
    logic [23:0] a;
    void'($urandom(32'hAE479953));
    for (k = 0; k < 1024; k++) ref_mem[k] = 8'h00;
    power_on(1'b0);
    check(sel_oe_n === ~EBB_DIR_RST_ROMOFF, "select direction after reset");
    slow = 8'h08;
    access(1'b0, 2'h0, 24'h200011);
    $display("test reset defaults done");
    dir = 8'hFF;
    set_cfg(1'b1);
    check(sel_oe_n === 8'h00, "select direction written");
    slow = 8'h00;
    for (k = 0; k < 16; k++) begin
      {slo, shi, ts, w8} = {{8{k[2]}}, {8{k[3]}}, {8{k[1]}}, {8{k[0]}}};
      set_cfg(1'b0);
      s = 2'(k % 3);
      a = rnd_addr(s);
      access(1'b1, s, a);
      access(1'b0, s, a);
    end
    $display("test width and state table done");
    for (k = 0; k < 60; k++) begin
      if (k % 4 == 0) begin
        {w8, ts, shi, slo} = $urandom;
        set_cfg(1'b0);
      end
      s = 2'($urandom % 3);
      access(1'($urandom), s, rnd_addr(s));
    end
    $display("test random traffic done");
    {pse, ts, shi, slo, w8} = {1'b1, 8'h0F, 8'hFF, 8'hFF, 8'h00};
    set_cfg(1'b0);
    check(pse_o === 1'b1, "pin stall status");
    slow = 8'h08;
    access(1'b0, 2'h1, 24'h000020);
    access(1'b0, 2'h1, 24'hE00020);
    slow = 8'h00;
    access(1'b0, 2'h1, 24'h000020);
    $display("test pin stall done");
    {pse, ts, shi, slo} = {1'b0, 8'hFF, 8'h00, 8'hFF};
    set_cfg(1'b0);
    @(posedge clk);
    #1 mrst = 1'b1;
    shi = 8'hFF;
    cfg_we = 1'b1;
    repeat (3) @(posedge clk);
    #1 mrst = 1'b0;
    cfg_we = 1'b0;
    shi = 8'h00;
    access(1'b0, 2'h0, 24'h400031);
    $display("test manual reset done");
    power_on(1'b1);
    check(sel_oe_n === ~EBB_DIR_RST_ROMON, "select direction rom enabled");
    $display("test rom enabled reset done");
    complete_run();
  end
endmodule
`default_nettype wire
